// ### common/swk_pkg.sv
// Shared constants and types for the status pin and local wake block
`default_nettype none
package swk_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int WAKE_FILTER_NS  = 2000;
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_TIMEOUT_NS   = 64000;
    localparam int RD_TIMEOUT_CYC  =
        (RD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Status info register layout (latched bits low active)
    // ------------------------------------------------------------
    localparam int SIR_W      = 16;
    localparam int B_LOCAL    = 0;
    localparam int B_REMOTE   = 1;
    localparam int B_RSVD     = 2;
    localparam int B_ERR_LO   = 4;
    localparam int N_ERR      = 7;
    localparam int B_ERR_SUM  = 11;
    localparam int B_SRC      = 12;
    localparam int B_EN_IND   = 13;
    localparam int B_STB_IND  = 14;
    localparam int B_PARITY   = 15;
    localparam logic [15:0] LATCH_MASK = 16'h17FB;
    localparam logic [15:0] LAT_RESET  = 16'hFFF7;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam int          APB_AW     = 8;
    localparam logic [7:0]  REG_STATUS = 8'h00;
    localparam logic [7:0]  REG_MODE   = 8'h04;
    localparam logic [7:0]  REG_CTRL   = 8'h08;
    localparam int          ST_FLAG    = 16;
    localparam int          ST_RD      = 17;
    localparam int          CTRL_WAKE_EN = 0;

    typedef enum logic [2:0] {
        MODE_NORMAL, MODE_RX_ONLY, MODE_GOTO_SLEEP, MODE_STANDBY, MODE_SLEEP
    } swk_mode_t;

    typedef enum logic [1:0] {RD_IDLE, RD_ARM, RD_SHIFT} swk_rd_t;
endpackage
`default_nettype wire

// ### hdl/swk_status_wake.sv
// Status pin multiplexer, status register and local wake detection
//
// Overview of operation
// - During readout the status pin carries serial data, else status.
// - The status pin is active low.
// - Normal command: pin shows error bit only.
// - Receive-only: error bit if wake flag clear, else wake source bit.
// - Sleep-type commands: pin mirrors wake flag; go-to-sleep enters sleep if flag clear, else standby.
// - Error bit and wake flag are held low active.
// - Indication follows the applied command, not the actual mode.
// - Pin is combinational from the latched status bits.
// - Pin releases only through the clearing sequence.
// - Stimuli not matching defined wake forms give no event.
// - Detector runs in every mode while battery good; mode decides what an event does.
// - Rising and falling wake input transitions both trigger.
// - A wake level counts only after the full filter time.
// - Low-power modes: local wake event sets status bit 0 low.
// - Normal and receive-only ignore local wake events.
// - Local wake sets the wake flag, leaves source bit 12 high.
// - Active wake flag in low power shows on receive outputs.
// - Sleep mode with active wake flag moves to standby.
// - Local wake detection is gated by battery supply good.
// - Pin shows local wake within filter plus reaction time.
// - Readout shifts bits LSB first per falling clock, wraps after 15.
// - Full readout in normal mode clears bits whose cause is gone.
`default_nettype none
module swk_status_wake #(
    parameter int WAKE_FILT_CYC = swk_pkg::WAKE_FILTER_CYC,
    parameter int RD_TMO_CYC    = swk_pkg::RD_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Host pins
    input  wire logic        mode_select_i,
    input  wire logic        standby_select_n_i,
    output logic             status_out_n_o,
    output logic             receive_activity_out_o,
    output logic             receive_data_out_o,
    // Wake and supply
    input  wire logic        wake_i,
    input  wire logic        bat_good_i,
    // On-chip causes, same clock
    input  wire logic        uv_sleep_i,
    input  wire logic        remote_wake_i,
    input  wire logic [6:0]  err_cause_i,
    output logic [2:0]       op_mode_o,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int FW = $clog2(WAKE_FILT_CYC + 1);
    localparam int TW = $clog2(RD_TMO_CYC + 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(WAKE_FILT_CYC - 1);
    localparam logic [TW-1:0] TMO_LOAD  = TW'(RD_TMO_CYC);
    localparam logic [3:0]    IDX_LAST  = 4'(swk_pkg::SIR_W - 1);

    if (WAKE_FILT_CYC < 2 || RD_TMO_CYC < 2) begin : g_chk
        $error("swk_status_wake: counts must be at least 2");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic       en_s;
    logic       stb_s;
    logic       wake_s;
    logic       bat_s;

    swk_sync #(.W(4)) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({bat_good_i, wake_i, standby_select_n_i, mode_select_i}),
        .sync_o  (pins_s)
    );
    assign en_s   = pins_s[0];
    assign stb_s  = pins_s[1];
    assign wake_s = pins_s[2];
    assign bat_s  = pins_s[3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    swk_pkg::swk_mode_t mode;
    swk_pkg::swk_mode_t next_mode;
    swk_pkg::swk_rd_t   rd_state;
    swk_pkg::swk_rd_t   next_rd_state;
    logic [15:0]        lat_n;
    logic               wflag_n;
    logic               wake_en;
    logic               en_prev;
    logic               wake_prev;
    logic               wake_qual;
    logic [FW-1:0]      filt_cnt;
    logic [TW-1:0]      tmr;
    logic [3:0]         idx;
    logic               shift_bit;
    logic               rx_ind_n;

    // ------------------------------------------------------------
    // Command decode and mode classes
    // ------------------------------------------------------------
    wire swk_pkg::swk_mode_t cmd_mode =
        stb_s ? (en_s ? swk_pkg::MODE_NORMAL : swk_pkg::MODE_RX_ONLY)
              : (en_s ? swk_pkg::MODE_GOTO_SLEEP : swk_pkg::MODE_STANDBY);
    wire low_pwr = (mode == swk_pkg::MODE_GOTO_SLEEP) ||
                   (mode == swk_pkg::MODE_STANDBY) ||
                   (mode == swk_pkg::MODE_SLEEP);
    wire rd_ok   = (mode == swk_pkg::MODE_NORMAL) ||
                   (mode == swk_pkg::MODE_RX_ONLY) ||
                   (mode == swk_pkg::MODE_STANDBY);

    // ------------------------------------------------------------
    // Local wake filter
    // ------------------------------------------------------------
    // Only clean, filtered level changes become events; glitches die here
    wire wake_edge = wake_s ^ wake_prev;
    wire next_filt_run = bat_s && !wake_edge;
    wire [FW-1:0] next_filt_cnt =
        !next_filt_run ? '0 :
        (filt_cnt == FILT_LAST) ? filt_cnt : filt_cnt + 1'b1;
    wire loc_evt = next_filt_run && (filt_cnt == FILT_LAST) &&
                   (wake_s != wake_qual);

    // ------------------------------------------------------------
    // Status register set and clear
    // ------------------------------------------------------------
    wire loc_set  = loc_evt && low_pwr && wake_en;
    wire rem_set  = remote_wake_i && low_pwr;
    wire wake_set = loc_set || rem_set;
    wire en_rise  = en_s && !en_prev;
    wire en_fall  = !en_s && en_prev;
    wire en_edge  = en_rise || en_fall;
    wire rd_busy  = (rd_state != swk_pkg::RD_IDLE);
    wire clr      = (rd_state == swk_pkg::RD_SHIFT) && en_fall &&
                    (idx == IDX_LAST) &&
                    (mode == swk_pkg::MODE_NORMAL);

    logic [15:0] set_vec;
    logic [15:0] cause_vec;
    always_comb begin
        set_vec = '0;
        cause_vec = '0;
        set_vec[swk_pkg::B_LOCAL]  = loc_set;
        set_vec[swk_pkg::B_REMOTE] = rem_set;
        set_vec[swk_pkg::B_SRC]    = rem_set;
        set_vec[swk_pkg::B_ERR_LO +: swk_pkg::N_ERR]   = err_cause_i;
        cause_vec[swk_pkg::B_ERR_LO +: swk_pkg::N_ERR] = err_cause_i;
    end

    // Set wins over a clear that lands in the same cycle
    wire [15:0] next_lat_n =
        (clr ? (lat_n | (swk_pkg::LATCH_MASK & ~cause_vec)) : lat_n) &
        ~(set_vec & swk_pkg::LATCH_MASK);
    wire next_wflag_n = wake_set ? 1'b0 : (clr ? 1'b1 : wflag_n);

    // Compose the full register from latched and live fields
    logic [15:0] status_info_reg;
    always_comb begin
        status_info_reg = lat_n;
        status_info_reg[swk_pkg::B_RSVD]    = 1'b1;
        status_info_reg[swk_pkg::B_ERR_SUM] =
            &lat_n[swk_pkg::B_ERR_LO +: swk_pkg::N_ERR];
        status_info_reg[swk_pkg::B_EN_IND]  = en_s;
        status_info_reg[swk_pkg::B_STB_IND] = stb_s;
        status_info_reg[swk_pkg::B_PARITY]  = 1'b0;
        status_info_reg[swk_pkg::B_PARITY]  = ^status_info_reg[14:0];
    end

    // ------------------------------------------------------------
    // Serial readout
    // ------------------------------------------------------------
    wire rd_start = !rd_busy && rd_ok && en_edge;
    wire rd_hold  = (rd_busy && rd_ok) || rd_start;
    wire [TW-1:0] next_tmr =
        (rd_start || en_edge) ? TMO_LOAD :
        (tmr != '0) ? tmr - 1'b1 : tmr;

    always_comb begin
        next_rd_state = rd_state;
        if (rd_busy && (!rd_ok || (tmr == '0 && !en_edge))) begin
            next_rd_state = swk_pkg::RD_IDLE;
        end else begin
            case (rd_state)
                swk_pkg::RD_IDLE: begin
                    if (rd_start) begin
                        next_rd_state = swk_pkg::RD_ARM;
                    end
                end
                swk_pkg::RD_ARM: begin
                    if (en_rise) begin
                        next_rd_state = swk_pkg::RD_SHIFT;
                    end
                end
                swk_pkg::RD_SHIFT: next_rd_state = swk_pkg::RD_SHIFT;
                default:           next_rd_state = swk_pkg::RD_IDLE;
            endcase
        end
    end

    wire shift_now = (rd_state == swk_pkg::RD_SHIFT) && en_fall;
    wire [3:0] next_idx = (rd_state != swk_pkg::RD_SHIFT) ? 4'h0 :
                          shift_now ? idx + 4'h1 : idx;
    wire next_shift_bit = !rd_busy ? 1'b1 :
                          shift_now ? status_info_reg[idx] : shift_bit;

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        if (uv_sleep_i) begin
            next_mode = swk_pkg::MODE_SLEEP;
        end else if (!rd_hold) begin
            case (mode)
                swk_pkg::MODE_SLEEP: begin
                    if (!wflag_n) begin
                        next_mode = swk_pkg::MODE_STANDBY;
                    end else if (stb_s) begin
                        next_mode = cmd_mode;
                    end
                end
                swk_pkg::MODE_GOTO_SLEEP: begin
                    if (cmd_mode != swk_pkg::MODE_GOTO_SLEEP) begin
                        next_mode = cmd_mode;
                    end else if (wflag_n) begin
                        next_mode = swk_pkg::MODE_SLEEP;
                    end else begin
                        next_mode = swk_pkg::MODE_STANDBY;
                    end
                end
                swk_pkg::MODE_STANDBY: begin
                    if (cmd_mode != swk_pkg::MODE_GOTO_SLEEP || wflag_n) begin
                        next_mode = cmd_mode;
                    end
                end
                default: next_mode = cmd_mode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status pin and receive outputs
    // ------------------------------------------------------------
    wire sel_n = !stb_s ? wflag_n :
                 en_s   ? status_info_reg[swk_pkg::B_ERR_SUM] :
                 (wflag_n ? status_info_reg[swk_pkg::B_ERR_SUM]
                          : status_info_reg[swk_pkg::B_SRC]);
    assign status_out_n_o = rd_busy ? shift_bit : sel_n;
    assign receive_activity_out_o = rx_ind_n;
    assign receive_data_out_o     = rx_ind_n;
    assign op_mode_o              = mode;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire hit_status = (paddr == swk_pkg::REG_STATUS);
    wire hit_mode   = (paddr == swk_pkg::REG_MODE);
    wire hit_ctrl   = (paddr == swk_pkg::REG_CTRL);
    wire hit        = hit_status || hit_mode || hit_ctrl;
    wire setup_rd   = psel && !penable && !pwrite;
    wire ctrl_wr    = psel && penable && pwrite && hit_ctrl;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_status) begin
            rd_mux[15:0]            = status_info_reg;
            rd_mux[swk_pkg::ST_FLAG] = wflag_n;
            rd_mux[swk_pkg::ST_RD]   = rd_busy;
        end else if (hit_mode) begin
            rd_mux[2:0] = mode;
        end else if (hit_ctrl) begin
            rd_mux[swk_pkg::CTRL_WAKE_EN] = wake_en;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode      <= swk_pkg::MODE_STANDBY;
            rd_state  <= swk_pkg::RD_IDLE;
            lat_n     <= swk_pkg::LAT_RESET;
            wflag_n   <= 1'b1;
            wake_en   <= 1'b1;
            en_prev   <= 1'b0;
            wake_prev <= 1'b0;
            wake_qual <= 1'b0;
            filt_cnt  <= '0;
            tmr       <= '0;
            idx       <= 4'h0;
            shift_bit <= 1'b1;
            rx_ind_n  <= 1'b1;
            prdata    <= 32'h0000_0000;
        end else begin
            mode      <= next_mode;
            rd_state  <= next_rd_state;
            lat_n     <= next_lat_n;
            wflag_n   <= next_wflag_n;
            en_prev   <= en_s;
            wake_prev <= wake_s;
            filt_cnt  <= next_filt_cnt;
            tmr       <= next_tmr;
            idx       <= next_idx;
            shift_bit <= next_shift_bit;
            rx_ind_n  <= !(low_pwr && !wflag_n);
            if (loc_evt) begin
                wake_qual <= wake_s;
            end
            if (ctrl_wr) begin
                wake_en <= pwdata[swk_pkg::CTRL_WAKE_EN];
            end
            if (setup_rd) begin
                prdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_readout_data;
        shift_now && rd_ok |=> status_out_n_o == $past(status_info_reg[idx]);
    endproperty
    a_readout_data: assert property (p_readout_data)
        else $error("status pin not serial data in readout");

    property p_normal_err;
        !rd_busy && stb_s && en_s |->
            status_out_n_o == &lat_n[10:4];
    endproperty
    a_normal_err: assert property (p_normal_err)
        else $error("normal command does not show error bit");

    property p_rx_only;
        !rd_busy && stb_s && !en_s |-> status_out_n_o ==
            (wflag_n ? &lat_n[10:4] : lat_n[12]);
    endproperty
    a_rx_only: assert property (p_rx_only)
        else $error("receive-only indication wrong");

    property p_sleep_flag;
        !rd_busy && !stb_s |-> status_out_n_o == wflag_n;
    endproperty
    a_sleep_flag: assert property (p_sleep_flag)
        else $error("sleep command does not mirror wake flag");

    property p_sleep_to_standby;
        mode == swk_pkg::MODE_SLEEP && !wflag_n && !uv_sleep_i |=>
            mode == swk_pkg::MODE_STANDBY;
    endproperty
    a_sleep_to_standby: assert property (p_sleep_to_standby)
        else $error("sleep did not leave on wake flag");

    property p_local_set;
        loc_evt && low_pwr && wake_en |=>
            !lat_n[0] && !wflag_n && lat_n[12] == $past(lat_n[12]) ||
            $past(remote_wake_i);
    endproperty
    a_local_set: assert property (p_local_set)
        else $error("local wake did not set bit 0 and flag");

    property p_active_ignore;
        loc_evt && !low_pwr && !remote_wake_i |=>
            !$fell(lat_n[0]) && !$fell(wflag_n);
    endproperty
    a_active_ignore: assert property (p_active_ignore)
        else $error("local wake set a bit in active mode");

    property p_filter_len;
        loc_evt |-> $stable(wake_s) && $past(wake_s, 2) == wake_s;
    endproperty
    a_filter_len: assert property (p_filter_len)
        else $error("wake event before filter time");

    property p_no_bat;
        !bat_s |=> !loc_evt;
    endproperty
    a_no_bat: assert property (p_no_bat)
        else $error("local wake detected without battery");

    property p_wrap;
        shift_now && idx == IDX_LAST |=> idx == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("readout index did not wrap after bit 15");
endmodule // swk_status_wake
`default_nettype wire

// ### hdl/swk_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`default_nettype none
module swk_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // swk_sync
`default_nettype wire

// ### sim/swk_host_model.sv
// Host controller model: mode pins and serial status readout
`default_nettype none
module swk_host_model (
    // Clock and status pin
    input  wire logic clock_i,
    input  wire logic status_out_n_i,
    // Mode pins
    output logic      mode_select_o,
    output logic      standby_select_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mode_select_o      = 1'b1;
        standby_select_n_o = 1'b1;
    end

    task automatic cmd(input logic stb, input logic en);
        @(posedge clock_i);
        standby_select_n_o <= stb;
        mode_select_o      <= en;
    endtask

    // Edges spaced well beyond the pin synchroniser delay
    task automatic edge_to(input logic en, input int hold);
        @(posedge clock_i);
        mode_select_o <= en;
        repeat (hold) @(posedge clock_i);
    endtask

    // Normal command: fall starts, rise enables, each fall shifts a bit
    task automatic readout(output logic [31:0] word);
        edge_to(1'b0, 8);
        edge_to(1'b1, 8);
        for (int k = 0; k < 32; k++) begin
            edge_to(1'b0, 6);
            word[k] = status_out_n_i;
            edge_to(1'b1, 4);
        end
    endtask
endmodule // swk_host_model
`default_nettype wire

// ### sim/tb_swk_status_wake.sv
// Self-checking bench for the status pin and local wake block
`default_nettype none
module tb_swk_status_wake;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    localparam int FILT = 4;
    localparam int TMO  = 40;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        mode_sel, stb_n, status_n, rx_act, rx_dat;
    logic        wake_i = 1'b0;
    logic        bat_good = 1'b1;
    logic        uv_sleep = 1'b0;
    logic        remote_wake = 1'b0;
    logic [6:0]  err_cause = 7'h00;
    logic [2:0]  op_mode;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, w;
    logic        pready, pslverr, perr;
    int          err_total = 0;
    int          total_checks = 0;

    always #4 clock_i = ~clock_i;

    swk_status_wake #(.WAKE_FILT_CYC(FILT), .RD_TMO_CYC(TMO))
    u_swk_status_wake (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .mode_select_i(mode_sel),
        .standby_select_n_i(stb_n), .status_out_n_o(status_n),
        .receive_activity_out_o(rx_act), .receive_data_out_o(rx_dat),
        .wake_i(wake_i), .bat_good_i(bat_good), .uv_sleep_i(uv_sleep),
        .remote_wake_i(remote_wake), .err_cause_i(err_cause),
        .op_mode_o(op_mode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    swk_host_model u_swk_host_model (
        .clock_i(clock_i), .status_out_n_i(status_n),
        .mode_select_o(mode_sel), .standby_select_n_o(stb_n));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic give_up(input string name);
        err_total++;
        $display("Error %s expected done seen timeout", name);
        summarize();
    endtask

    // Settled sampling point after n rising edges
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd);
        int n;
        @(posedge clock_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock_i);
            if (pready === 1'b1) break;
        end
        if (n == 20) give_up("apb ready");
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wake(input logic v, input int hold);
        @(posedge clock_i);
        wake_i <= v;
        repeat (hold) @(posedge clock_i);
    endtask

    // Wake path has no fixed latency, only an upper bound
    task automatic wait_pin_low();
        int n;
        for (n = 0; n < FILT + 14; n++) begin
            @(negedge clock_i);
            if (status_n === 1'b0) break;
        end
        if (n == FILT + 14) give_up("status pin wake");
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clock_i);
        give_up("run length");
    end

    initial begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        cyc(60);
        apb(1'b1, swk_pkg::REG_CTRL, 32'h0);
        apb(1'b0, swk_pkg::REG_CTRL, 32'h0);
        chk("ctrl written", rdat, 32'h0);
        apb(1'b1, swk_pkg::REG_CTRL, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", perr, 1'b1);
        chk("unmapped data", rdat, 32'h0);
        apb(1'b0, swk_pkg::REG_MODE, 32'h0);
        chk("mode normal", rdat[2:0], swk_pkg::MODE_NORMAL);
        cyc(1);
        chk("pin no error", status_n, 1'b1);
        @(posedge clock_i);
        err_cause <= 7'h01;
        @(posedge clock_i);
        err_cause <= 7'h00;
        cyc(4);
        chk("pin error", status_n, 1'b0);
        wake(1'b1, 20);
        cyc(20);
        chk("pin error held", status_n, 1'b0);
        apb(1'b0, swk_pkg::REG_STATUS, 32'h0);
        chk("local bit normal", rdat[0], 1'b1);
        chk("flag normal", rdat[swk_pkg::ST_FLAG], 1'b1);
        $display("test normal done");
        u_swk_host_model.cmd(1'b1, 1'b0);
        cyc(60);
        chk("pin rx error", status_n, 1'b0);
        u_swk_host_model.cmd(1'b0, 1'b0);
        cyc(10);
        chk("pin standby", status_n, 1'b1);
        @(posedge clock_i);
        bat_good <= 1'b0;
        wake(1'b0, 20);
        apb(1'b0, swk_pkg::REG_STATUS, 32'h0);
        chk("flag no supply", rdat[swk_pkg::ST_FLAG], 1'b1);
        wake(1'b1, 20);
        @(posedge clock_i);
        bat_good <= 1'b1;
        wake(1'b0, 2);
        wake(1'b1, 20);
        cyc(1);
        chk("pin spike", status_n, 1'b1);
        wake(1'b0, 0);
        wait_pin_low();
        cyc(1);
        chk("rx act flag", rx_act, 1'b0);
        chk("rx data flag", rx_dat, 1'b0);
        apb(1'b0, swk_pkg::REG_STATUS, 32'h0);
        chk("local bit", rdat[0], 1'b0);
        chk("source bit", rdat[12], 1'b1);
        chk("flag set", rdat[swk_pkg::ST_FLAG], 1'b0);
        u_swk_host_model.cmd(1'b1, 1'b0);
        cyc(10);
        chk("pin rx source", status_n, 1'b1);
        $display("test wake done");
        u_swk_host_model.cmd(1'b1, 1'b1);
        cyc(60);
        u_swk_host_model.readout(w);
        chk("readout first", w[12:0], 13'h17E6);
        chk("readout second", w[28:16], 13'h1FFF);
        cyc(60);
        chk("pin cleared", status_n, 1'b1);
        $display("test readout done");
        u_swk_host_model.cmd(1'b0, 1'b1);
        cyc(20);
        chk("sleep entered", op_mode, swk_pkg::MODE_SLEEP);
        chk("pin sleep", status_n, 1'b1);
        wake(1'b1, 0);
        wait_pin_low();
        cyc(6);
        chk("sleep to standby", op_mode, swk_pkg::MODE_STANDBY);
        @(posedge clock_i);
        remote_wake <= 1'b1;
        @(posedge clock_i);
        remote_wake <= 1'b0;
        u_swk_host_model.cmd(1'b1, 1'b0);
        cyc(60);
        chk("pin rx remote", status_n, 1'b0);
        u_swk_host_model.cmd(1'b1, 1'b1);
        cyc(10);
        @(posedge clock_i);
        uv_sleep <= 1'b1;
        cyc(10);
        chk("uv sleep", op_mode, swk_pkg::MODE_SLEEP);
        chk("pin follows command", status_n, 1'b1);
        $display("test sleep done");
        summarize();
    end
endmodule // tb_swk_status_wake
`default_nettype wire
